// file: cscf_defs.vh
// Constants for the CELP speech codec frame engine
// How it works
// RULE1: Short-term synthesis is all-pole 1/A(z) with exactly ten predictor coefficients.
// RULE2: Pitch filter is an adaptive codebook; short delays repeat past excitation.
// RULE3: Innovation is gain scaled, then pitch filtered, then short-term filtered.
// RULE4: Error is weighted by A(z)/A(z/gamma) with gamma 0.85.
// RULE5: Weighting and synthesis filters both use the quantized coefficients.
// RULE6: Each sub-frame keeps the candidate with least weighted error.
// RULE7: Innovation shaped by impulse response of A(z/0.75)/A(z/0.85), Toeplitz.
// RULE8: Frames are 30 ms; new LP parameters are sent each frame.
// RULE9: Four sub-frames of 60 samples; pitch and code parameters per sub-frame.
// RULE10: Exactly 137 bits leave the encoder per frame.
// RULE11: LP filter takes 26 bits; pitch delay 8 then 5,5,5 bits.
// RULE12: Each sub-frame carries 16 code bits and 6 gain bits.
// RULE13: Pre-filter y=x/2-x1/2+alpha*y1, alpha 32735/32768.
// RULE14: Decoder output doubled and clamped, never wrapped.
// RULE15: Sample source delivers 8 kHz samples, one per sample period.
// RULE16: Filter state, codebook history and held parameters clear on reset.
// RULE17: Arithmetic is 16-bit two's complement with saturation.
`ifndef CSCF_DEFS_VH
`define CSCF_DEFS_VH
`define CSCF_ORDER 10
`define CSCF_SAMPLE_HZ 8000
`define CSCF_FRAME_MS 30
`define CSCF_MS_PER_S 1000
`define CSCF_FRAME_LEN (`CSCF_FRAME_MS * `CSCF_SAMPLE_HZ / `CSCF_MS_PER_S)
`define CSCF_SUBFRAMES 4
`define CSCF_SUB_LEN 60
`define CSCF_SUB_LAST 6'h3B
`define CSCF_SUB_IDX_LAST 2'h3
`define CSCF_FRAME_BITS 137
`define CSCF_LP_BITS 26
`define CSCF_P0_BITS 8
`define CSCF_PN_BITS 5
`define CSCF_CODE_BITS 16
`define CSCF_GAIN_BITS 6
`define CSCF_ALPHA 16'sh7FDF
`define CSCF_ALPHA_SH 15
`define CSCF_GAMMA_SH 15
`define CSCF_COEF_SH 12
`define CSCF_GAIN_SH 12
`define CSCF_SMAX 40'sh00_0000_7FFF
`define CSCF_SMIN 40'shFF_FFFF_8000
`define CSCF_ERR_MAX 40'h7F_FFFF_FFFF
`endif

// file: cscf_codec.v
// Frame engine of the algebraic CELP codec: pre-filter, synthesis, search, packing
`include "cscf_defs.vh"
module cscf_codec #(
  parameter ACB_DEPTH = 256,
  parameter ACB_AW = 8
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_sample_valid,
  input wire signed [15:0] i_sample,
  input wire signed [15:0] i_innov,
  input wire [159:0] i_lpc_coef,
  input wire signed [15:0] i_code_gain,
  input wire signed [15:0] i_pitch_gain,
  input wire [7:0] i_pitch_delay,
  input wire [15:0] i_cand_index,
  input wire i_cand_first,
  input wire [25:0] i_lp_index,
  input wire [7:0] i_pitch_index,
  input wire [15:0] i_code_index,
  input wire [5:0] i_gain_index,
  output reg signed [15:0] o_pre_sample,
  output reg signed [15:0] o_dec_sample,
  output reg o_out_valid,
  output reg [15:0] o_best_index,
  output reg [39:0] o_best_error,
  output reg o_best_valid,
  output reg [1:0] o_sub_idx,
  output reg [`CSCF_FRAME_BITS-1:0] o_frame_bits,
  output reg o_frame_valid
);

  // Saturate a wide value to 16 bits
  function signed [15:0] sat16;
    input signed [39:0] v;
    begin
      if (v > `CSCF_SMAX) begin
        sat16 = 16'sh7FFF;
      end else if (v < `CSCF_SMIN) begin
        sat16 = 16'sh8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // Sign extend a 32-bit product
  function signed [39:0] sx40;
    input signed [31:0] v;
    begin
      sx40 = {{8{v[31]}}, v};
    end
  endfunction

  // Powers of gamma in Q15: sel 1 for 0.85, 0 for 0.75
  function signed [15:0] gpow;
    input sel;
    input [3:0] k;
    begin
      case ({sel, k})
        5'h10: gpow = 16'sh6CCD;
        5'h11: gpow = 16'sh5C7B;
        5'h12: gpow = 16'sh4E9C;
        5'h13: gpow = 16'sh42D1;
        5'h14: gpow = 16'sh38CB;
        5'h15: gpow = 16'sh3046;
        5'h16: gpow = 16'sh2909;
        5'h17: gpow = 16'sh22E1;
        5'h18: gpow = 16'sh1DA6;
        5'h19: gpow = 16'sh1933;
        5'h00: gpow = 16'sh6000;
        5'h01: gpow = 16'sh4800;
        5'h02: gpow = 16'sh3600;
        5'h03: gpow = 16'sh2880;
        5'h04: gpow = 16'sh1E60;
        5'h05: gpow = 16'sh16C8;
        5'h06: gpow = 16'sh1116;
        5'h07: gpow = 16'sh0CD1;
        5'h08: gpow = 16'sh099C;
        5'h09: gpow = 16'sh0735;
        default: gpow = 16'sh0000;
      endcase
    end
  endfunction

  reg signed [15:0] x_prev_ff;
  reg signed [15:0] y_prev_ff;
  reg [5:0] sub_cnt_ff;
  reg [1:0] sub_idx_ff;
  reg [159:0] syn_h_ff;
  reg [159:0] cin_h_ff;
  reg [159:0] shp_h_ff;
  reg [159:0] err_h_ff;
  reg [159:0] wer_h_ff;
  reg [ACB_AW-1:0] acb_wr_ff;
  reg signed [15:0] acb_mem [0:ACB_DEPTH-1];
  reg [39:0] acc_ff;
  reg [25:0] lp_ff;
  reg [7:0] p0_ff;
  reg [14:0] pn_ff;
  reg [63:0] code_ff;
  reg [23:0] gain_ff;
  integer m;
  integer r;

  // Pre-filter removes DC and halves the level
  // RULE13: offset compensation recursion
  // Signed cast keeps the sign bit through the halving shift
  wire signed [39:0] pre_x = $signed({{24{i_sample[15]}}, i_sample}) >>> 1;
  wire signed [39:0] pre_x1 = $signed({{24{x_prev_ff[15]}}, x_prev_ff}) >>> 1;
  wire signed [31:0] pre_fbp = `CSCF_ALPHA * y_prev_ff; // Full 32-bit product
  wire signed [39:0] pre_fb = sx40(pre_fbp) >>> `CSCF_ALPHA_SH;
  wire signed [15:0] pre_y = sat16(pre_x - pre_x1 + pre_fb);

  // Shaping state starts from zero each sub-frame
  wire shp_clr = (sub_cnt_ff == 6'h00);
  wire [159:0] cin_m = shp_clr ? 160'h0 : cin_h_ff;
  wire [159:0] shp_m = shp_clr ? 160'h0 : shp_h_ff;

  wire [319:0] p_syn;
  wire [319:0] p_cz;
  wire [319:0] p_cp;
  wire [319:0] p_ez;
  wire [319:0] p_ep;

  // Per-tap products of all filters, one set per coefficient
  genvar g;
  generate
    for (g = 0; g < `CSCF_ORDER; g = g + 1) begin : tap
      // RULE5: quantized coefficients feed every filter
      wire signed [15:0] a = i_lpc_coef[16*g +: 16];
      wire signed [31:0] a85_w = a * gpow(1'b1, g[3:0]);
      wire signed [31:0] a75_w = a * gpow(1'b0, g[3:0]);
      wire signed [15:0] a85 = a85_w[30:15];
      wire signed [15:0] a75 = a75_w[30:15];
      // RULE1: ten-tap all-pole synthesis products
      assign p_syn[32*g +: 32] = a * $signed(syn_h_ff[16*g +: 16]);
      // RULE7: shaping numerator and denominator taps
      assign p_cz[32*g +: 32] = a75 * $signed(cin_m[16*g +: 16]);
      assign p_cp[32*g +: 32] = a85 * $signed(shp_m[16*g +: 16]);
      // RULE4: weighting filter numerator and denominator taps
      assign p_ez[32*g +: 32] = a * $signed(err_h_ff[16*g +: 16]);
      assign p_ep[32*g +: 32] = a85 * $signed(wer_h_ff[16*g +: 16]);
    end
  endgenerate

  reg signed [39:0] s_syn;
  reg signed [39:0] s_cz;
  reg signed [39:0] s_cp;
  reg signed [39:0] s_ez;
  reg signed [39:0] s_ep;

  // Tap sums
  always @* begin
    s_syn = 40'sh00_0000_0000;
    s_cz = 40'sh00_0000_0000;
    s_cp = 40'sh00_0000_0000;
    s_ez = 40'sh00_0000_0000;
    s_ep = 40'sh00_0000_0000;
    for (m = 0; m < `CSCF_ORDER; m = m + 1) begin
      s_syn = s_syn + sx40(p_syn[32*m +: 32]);
      s_cz = s_cz + sx40(p_cz[32*m +: 32]);
      s_cp = s_cp + sx40(p_cp[32*m +: 32]);
      s_ez = s_ez + sx40(p_ez[32*m +: 32]);
      s_ep = s_ep + sx40(p_ep[32*m +: 32]);
    end
  end

  // RULE7: Toeplitz shaping as zero-state filtering per sub-frame
  wire signed [39:0] innov_x = {{24{i_innov[15]}}, i_innov};
  wire signed [15:0] shaped = sat16(innov_x + ((s_cz - s_cp) >>> `CSCF_COEF_SH));

  // RULE2: delayed read repeats excitation when delay is below 60
  wire [ACB_AW-1:0] acb_rd = acb_wr_ff - i_pitch_delay[ACB_AW-1:0];
  wire signed [15:0] acb_v = acb_mem[acb_rd];

  // RULE3: gain scaling then pitch contribution forms the excitation
  wire signed [31:0] gc_p = i_code_gain * shaped;
  wire signed [31:0] gp_p = i_pitch_gain * acb_v;
  wire signed [39:0] gc_t = sx40(gc_p);
  wire signed [39:0] gp_t = sx40(gp_p);
  wire signed [15:0] exc = sat16((gc_t + gp_t) >>> `CSCF_GAIN_SH);

  // RULE1: all-pole short-term synthesis
  // RULE17: every stage saturates to 16 bits
  wire signed [39:0] exc_x = {{24{exc[15]}}, exc};
  wire signed [15:0] syn = sat16(exc_x - (s_syn >>> `CSCF_COEF_SH));

  // RULE4: perceptually weighted error against pre-processed speech
  wire signed [39:0] diff_x = {{24{pre_y[15]}}, pre_y} - {{24{syn[15]}}, syn};
  wire signed [15:0] err = sat16(diff_x);
  wire signed [39:0] err_x = {{24{err[15]}}, err};
  wire signed [15:0] wer = sat16(err_x + ((s_ez - s_ep) >>> `CSCF_COEF_SH));
  wire signed [31:0] wer_sq = wer * wer;
  wire [39:0] acc_nxt = acc_ff + {8'h00, wer_sq};

  // RULE14: decoder output doubled with clamp
  wire signed [39:0] syn_x2 = {{24{syn[15]}}, syn} <<< 1;
  wire signed [15:0] dec_v = sat16(syn_x2);

  wire sub_end = i_sample_valid && (sub_cnt_ff == `CSCF_SUB_LAST);
  wire frame_end = sub_end && (sub_idx_ff == `CSCF_SUB_IDX_LAST);

  // Filter state, history and sample timing
  // RULE16: state cleared on reset, kept over frame edges except the shaping state, which restarts each sub-frame
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      x_prev_ff <= 16'sh0000;
      y_prev_ff <= 16'sh0000;
      sub_cnt_ff <= 6'h00;
      sub_idx_ff <= 2'h0;
      syn_h_ff <= 160'h0;
      cin_h_ff <= 160'h0;
      shp_h_ff <= 160'h0;
      err_h_ff <= 160'h0;
      wer_h_ff <= 160'h0;
      acb_wr_ff <= {ACB_AW{1'b0}};
      acc_ff <= 40'h00_0000_0000;
      for (r = 0; r < ACB_DEPTH; r = r + 1) begin
        acb_mem[r] <= 16'sh0000;
      end
    end else if (i_sample_valid) begin
      x_prev_ff <= i_sample;
      y_prev_ff <= pre_y;
      syn_h_ff <= {syn_h_ff[143:0], syn};
      cin_h_ff <= {cin_m[143:0], i_innov};
      shp_h_ff <= {shp_m[143:0], shaped};
      err_h_ff <= {err_h_ff[143:0], err};
      wer_h_ff <= {wer_h_ff[143:0], wer};
      acb_mem[acb_wr_ff] <= exc;
      acb_wr_ff <= acb_wr_ff + {{(ACB_AW-1){1'b0}}, 1'b1};
      // RULE9: 60 samples per sub-frame, four per frame
      if (sub_end) begin
        sub_cnt_ff <= 6'h00;
        sub_idx_ff <= sub_idx_ff + 2'h1;
        acc_ff <= 40'h00_0000_0000;
      end else begin
        sub_cnt_ff <= sub_cnt_ff + 6'h01;
        acc_ff <= acc_nxt;
      end
    end
  end

  // Sample outputs and candidate choice
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pre_sample <= 16'sh0000;
      o_dec_sample <= 16'sh0000;
      o_out_valid <= 1'b0;
      o_best_index <= 16'h0000;
      o_best_error <= `CSCF_ERR_MAX;
      o_best_valid <= 1'b0;
      o_sub_idx <= 2'h0;
    end else begin
      o_out_valid <= i_sample_valid;
      o_best_valid <= sub_end;
      if (i_sample_valid) begin
        o_pre_sample <= pre_y;
        o_dec_sample <= dec_v;
        o_sub_idx <= sub_idx_ff;
      end
      // RULE6: keep the candidate with the least weighted error
      if (sub_end && (i_cand_first || (acc_nxt < o_best_error))) begin
        o_best_index <= i_cand_index;
        o_best_error <= acc_nxt;
      end
    end
  end

  // Parameter capture and frame packing
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      lp_ff <= 26'h000_0000;
      p0_ff <= 8'h00;
      pn_ff <= 15'h0000;
      code_ff <= 64'h0000_0000_0000_0000;
      gain_ff <= 24'h00_0000;
      o_frame_bits <= {`CSCF_FRAME_BITS{1'b0}};
      o_frame_valid <= 1'b0;
    end else begin
      o_frame_valid <= frame_end;
      if (sub_end) begin
        // RULE12: 16 code bits and 6 gain bits per sub-frame
        code_ff[`CSCF_CODE_BITS*sub_idx_ff +: `CSCF_CODE_BITS] <= i_code_index;
        gain_ff[`CSCF_GAIN_BITS*sub_idx_ff +: `CSCF_GAIN_BITS] <= i_gain_index;
        // RULE11: 8 pitch bits first, 5 in later sub-frames
        if (sub_idx_ff == 2'h0) begin
          p0_ff <= i_pitch_index;
        end else begin
          pn_ff[`CSCF_PN_BITS*(sub_idx_ff-2'h1) +: `CSCF_PN_BITS] <= i_pitch_index[4:0];
        end
      end
      // RULE8: LP index held once per 30 ms frame
      // RULE10: 137-bit frame word
      if (frame_end) begin
        lp_ff <= i_lp_index;
        o_frame_bits <= {i_lp_index, p0_ff, code_ff[15:0], gain_ff[5:0],
                         pn_ff[4:0], code_ff[31:16], gain_ff[11:6],
                         pn_ff[9:5], code_ff[47:32], gain_ff[17:12],
                         i_pitch_index[4:0], i_code_index, i_gain_index};
      end
    end
  end

endmodule

// file: cscf_codec_props.sv
// Port-level assertions for the CELP frame engine
module cscf_codec_chk (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_sample_valid,
  input wire signed [15:0] o_pre_sample,
  input wire signed [15:0] o_dec_sample,
  input wire o_out_valid,
  input wire [39:0] o_best_error,
  input wire o_best_valid,
  input wire [1:0] o_sub_idx,
  input wire o_frame_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  // Strobes counted through one 240-sample frame
  always @(posedge i_clock) begin
    if (!i_reset_n) cnt_ff <= 8'h00;
    else if (i_sample_valid) cnt_ff <= (cnt_ff == 8'hEF) ? 8'h00 : cnt_ff + 8'h01;
  end
  pulse_follow_a: assert property (i_sample_valid |=> o_out_valid)
    else $error("no output pulse after a sample");
  no_spurious_a: assert property (!i_sample_valid |=> !o_out_valid)
    else $error("output pulse without a sample");
  sub_index_a: assert property (i_sample_valid |=> o_sub_idx == 2'($past(cnt_ff) / 8'd60))
    else $error("sub-frame index wrong");
  sub_end_a: assert property (o_best_valid == ($past(i_sample_valid) && ($past(cnt_ff) % 8'd60 == 8'd59)))
    else $error("best pulse not at sub-frame end");
  frame_end_a: assert property (o_frame_valid == ($past(i_sample_valid) && $past(cnt_ff) == 8'hEF))
    else $error("frame pulse not at frame end");
  dec_double_a: assert property (o_out_valid |-> !o_dec_sample[0] || o_dec_sample == 16'h7FFF)
    else $error("decoder output not doubled");
  data_hold_a: assert property (!i_sample_valid |=> $stable(o_pre_sample) && $stable(o_dec_sample))
    else $error("output data moved without a sample");
  reset_clear_a: assert property (disable iff (1'b0) !i_reset_n |=> o_best_error == 40'h7F_FFFF_FFFF && !o_out_valid)
    else $error("reset state wrong");
  cover property (o_best_valid);
  cover property (o_frame_valid);
  cover property (o_out_valid && o_dec_sample == 16'h7FFF);
  cover property (i_sample_valid && $past(i_sample_valid));
endmodule
bind cscf_codec cscf_codec_chk u_chk (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_sample_valid(i_sample_valid), .o_pre_sample(o_pre_sample), .o_dec_sample(o_dec_sample),
  .o_out_valid(o_out_valid), .o_best_error(o_best_error), .o_best_valid(o_best_valid),
  .o_sub_idx(o_sub_idx), .o_frame_valid(o_frame_valid));

// file: cscf_sink.sv
// Channel coder stand-in that takes each finished frame
module cscf_sink (
  input wire i_clock,
  input wire i_frame_valid,
  input wire [136:0] i_frame_bits,
  output logic [136:0] o_last_frame,
  output int o_frames
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_frames = 0;
  // Frame taken whole on its one-cycle pulse
  always @(posedge i_clock) begin
    if (i_frame_valid) begin
      o_last_frame <= i_frame_bits;
      o_frames <= o_frames + 1;
    end
  end
endmodule

// file: cscf_codec_tb.sv
// Self-checking bench for the CELP frame engine
module cscf_codec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0;
  logic i_reset_n;
  logic i_sample_valid = 0;
  logic i_cand_first = 0;
  logic signed [15:0] i_sample = 0, i_innov = 0, i_code_gain = 0, i_pitch_gain = 16'h1000;
  logic [7:0] i_pitch_delay = 8'h01, i_pitch_index = 0;
  logic [15:0] i_cand_index = 0, i_code_index = 0;
  logic [25:0] i_lp_index = 0;
  logic [5:0] i_gain_index = 0;
  wire signed [15:0] o_pre_sample, o_dec_sample;
  wire o_out_valid, o_best_valid, o_frame_valid;
  wire [15:0] o_best_index;
  wire [39:0] o_best_error;
  wire [1:0] o_sub_idx;
  wire [136:0] o_frame_bits, last_frame;
  int frames, failures = 0, num_checks = 0;
  int n, x1, y1, gc, tst;
  int exc[$];
  longint err_sum, best_err;
  logic [15:0] best_idx;
  logic [136:0] fb, fb_done;
  logic [159:0] lpc = 0;
  int a[10], a75[10], a85[10], ch[10], sh[10], yh[10], eh[10], wh[10];
  always #5 i_clock = ~i_clock;
  cscf_codec dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .i_innov(i_innov), .i_lpc_coef(lpc),
    .i_code_gain(i_code_gain), .i_pitch_gain(i_pitch_gain), .i_pitch_delay(i_pitch_delay),
    .i_cand_index(i_cand_index), .i_cand_first(i_cand_first), .i_lp_index(i_lp_index),
    .i_pitch_index(i_pitch_index), .i_code_index(i_code_index), .i_gain_index(i_gain_index),
    .o_pre_sample(o_pre_sample), .o_dec_sample(o_dec_sample), .o_out_valid(o_out_valid),
    .o_best_index(o_best_index), .o_best_error(o_best_error), .o_best_valid(o_best_valid),
    .o_sub_idx(o_sub_idx), .o_frame_bits(o_frame_bits), .o_frame_valid(o_frame_valid));
  cscf_sink u_sink (.i_clock(i_clock), .i_frame_valid(o_frame_valid),
    .i_frame_bits(o_frame_bits), .o_last_frame(last_frame), .o_frames(frames));
  // Clamp to the 16-bit range
  function automatic int sat(input longint v);
    return int'(v > 32767 ? 32767 : (v < -32768 ? -32768 : v));
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [136:0] seen, input logic [136:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset clears filter and codebook history
  task automatic do_reset();
    i_reset_n = 0;
    repeat (4) @(negedge i_clock);
    i_reset_n = 1;
    n = 0;
    x1 = 0;
    y1 = 0;
    exc = {};
    best_err = 40'h7F_FFFF_FFFF;
    // small random quantized coefficients, gamma powers in Q15
    for (int k = 0; k < 10; k++) begin
      a[k] = int'($urandom_range(512)) - 256;
      a75[k] = (a[k] * int'((0.75 ** (k + 1)) * 32768.0)) >>> 15;
      a85[k] = (a[k] * int'((0.85 ** (k + 1)) * 32768.0)) >>> 15;
      lpc[16*k +: 16] = 16'(a[k]);
      yh[k] = 0;
      eh[k] = 0;
      wh[k] = 0;
    end
  endtask
  // One sample through stimulus and reference model
  task automatic strobe(input int gap);
    int s, sub, p, c, y, d, e, w, pb, v, q, r;
    longint sz, sp, ss, se, sw;
    s = n % 60;
    sub = (n % 240) / 60;
    if (s == 0) begin
      i_pitch_delay = 8'($urandom_range(80, 1));
      err_sum = 0;
      foreach (ch[k]) begin
        ch[k] = 0;
        sh[k] = 0;
      end
    end
    p = int'($urandom_range(8000)) - 4000;
    c = int'($urandom_range(4000)) - 2000;
    i_sample = 16'(p);
    i_innov = 16'(c);
    i_cand_index = 16'($urandom);
    i_cand_first = 1'($urandom);
    {i_lp_index, i_pitch_index, i_code_index, i_gain_index} = 56'({$urandom, $urandom});
    i_sample_valid = 1;
    y = sat((p >>> 1) - (x1 >>> 1) + ((32735 * y1) >>> 15));
    x1 = p;
    y1 = y;
    sz = 0;
    sp = 0;
    ss = 0;
    se = 0;
    sw = 0;
    foreach (a[k]) begin
      sz += longint'(a75[k]) * ch[k];
      sp += longint'(a85[k]) * sh[k];
      ss += longint'(a[k]) * yh[k];
      se += longint'(a[k]) * eh[k];
      sw += longint'(a85[k]) * wh[k];
    end
    // shaping filter, zero state at each sub-frame start
    v = sat(c + ((sz - sp) >>> 12));
    d = exc.size() >= i_pitch_delay ? exc[exc.size() - i_pitch_delay] : 0;
    e = sat((longint'(gc) * v + 4096 * d) >>> 12);
    exc.push_back(e);
    q = sat(e - (ss >>> 12));
    r = sat(y - q);
    w = sat(r + ((se - sw) >>> 12));
    for (int k = 9; k > 0; k--) begin
      ch[k] = ch[k-1];
      sh[k] = sh[k-1];
      yh[k] = yh[k-1];
      eh[k] = eh[k-1];
      wh[k] = wh[k-1];
    end
    ch[0] = c;
    sh[0] = v;
    yh[0] = q;
    eh[0] = r;
    wh[0] = w;
    err_sum += longint'(w) * w;
    @(negedge i_clock);
    check("pre", o_pre_sample, 16'(y));
    check("dec", o_dec_sample, 16'(sat(2 * q)));
    check("ovalid", o_out_valid, 1);
    check("bvalid", o_best_valid, s == 59);
    check("fvalid", o_frame_valid, s == 59 && sub == 3);
    if (s == 59) begin
      if (i_cand_first || err_sum < best_err) begin
        best_err = err_sum;
        best_idx = i_cand_index;
      end
      check("bidx", o_best_index, best_idx);
      check("berr", o_best_error, 40'(best_err));
      check("sub", o_sub_idx, sub);
      pb = sub == 0 ? int'(i_pitch_index) : int'(i_pitch_index[4:0]);
      fb = sub == 0 ? 137'(pb) : ((fb << 5) | 137'(pb));
      fb = (fb << 22) | 137'({i_code_index, i_gain_index});
      if (sub == 3) begin
        fb_done = (137'(i_lp_index) << 111) | fb;
        check("frame", o_frame_bits, fb_done);
      end
    end
    n++;
    // strobe spacing shortened, back to back allowed
    if (gap > 0) begin
      i_sample_valid = 0;
      repeat (gap) @(negedge i_clock);
    end
  endtask
  initial begin
    void'($urandom(32'hf8783987));
    for (tst = 0; tst < 2; tst++) begin
      do_reset();
      gc = 2048 << tst;
      i_code_gain = 16'(gc);
      repeat (240) strobe(tst == 0 ? int'($urandom_range(3)) : 0);
      i_sample_valid = 0;
      repeat (2) @(negedge i_clock);
      check("frames", frames, tst + 1);
      check("sink", last_frame, fb_done);
      $display("Test %0d done, checks %0d", tst, num_checks);
    end
    end_sim();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100us;
    failures++;
    end_sim();
  end
endmodule
